// [cgscb_bench.sv]
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`default_nettype none
module cgscb_bench;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic        scl_clk, sda_drv, sda_out, sda_oe, gfx, usb, dot, spr, pwr, m133;
	logic [12:0] mem;
	logic [3:0]  pci;
	logic [55:0] cfg;
	wire logic   sda_in = sda_drv & ~sda_oe; // open drain with pull-up
	int          err_total = 0;
	int          samples_checked = 0;
	localparam logic [55:0] DFLT = 56'h00_00_07_02_ff_ff_06;
	localparam logic [55:0] PAT = 56'h00_00_05_01_5a_a5_08; // reserved bits zero
	always #5 clk = ~clk;
	cgscb_top cgscb_top_i (.clk(clk), .resetn(resetn), .scl_clk(scl_clk), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .memory_clock_outputs_en(mem),
		.fixed66_graphics_port_clock_en(gfx), .pci_slot_clock_outputs_en(pci), .usb_clock_en(usb),
		.dot_clock_en(dot), .spread_enable(spr), .power_down_input_n_select(pwr),
		.mem133_mode_enable(m133), .config_bytes(cfg));
	cgscb_ctl cgscb_ctl_i (.scl(scl_clk), .sda(sda_drv), .sda_oe(sda_oe));
	task automatic cmp(input string n, input logic [55:0] e, input logic [55:0] s);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic chk(input logic [55:0] e);
		cmp("bytes", e, cfg);
		cmp("outputs", 56'({e[22:18], e[15:8], e[23], e[34:32], e[17], e[3:1], e[25:24], 2'b00}),
			56'({mem, gfx, pci, spr, dot, usb, pwr, m133, sda_out, sda_oe}));
	endtask
	task automatic wr(input logic [7:0] a, input int n, input logic [55:0] d, input int tail, input int ak);
		cgscb_ctl_i.frame(a, n, d, tail);
		repeat (8) @(posedge clk);
		#1 cmp("acks", 56'(ak), 56'(cgscb_ctl_i.acks));
	endtask
	task automatic do_reset();
		@(posedge clk);
		#1 resetn = 1'b0;
		repeat (16) @(posedge clk);
		#1 resetn = 1'b1;
		repeat (3) @(posedge clk);
		// keep link edges off the system clock edges so the synchronisers see no race
		#1;
	endtask
	task automatic wrap_up();
		if (err_total == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// a run takes about 9 us, so 100 us means a hang
	initial begin
		#100000;
		err_total++;
		wrap_up();
	end
	initial begin
		do_reset();
		chk(DFLT);
		wr(8'hd2, 7, PAT, 0, 10);
		chk(PAT);
		wr(8'hd2, 2, DFLT, 4, 5);
		chk({PAT[55:16], DFLT[15:0]});
		wr(8'hd4, 1, 56'h0, 0, 0);
		chk({PAT[55:16], DFLT[15:0]});
		wr(8'hd2, 5, 56'h0, 0, 8);
		chk(56'h0);
		do_reset();
		chk(DFLT);
		wrap_up();
	end
endmodule // cgscb_bench
`default_nettype wire

// [cgscb_ctl.sv]
// two-wire controller model that writes configuration frames
`timescale 1ns/1ns
`default_nettype none
module cgscb_ctl (
	output var  logic scl,
	output var  logic sda,
	input  wire logic sda_oe
);
	int acks;
	initial begin
		scl = 1'b1; // clock stands high between frames
		sda = 1'b1;
	end
	task automatic put(input logic [7:0] b, input int nb);
		for (int i = 7; i > 7 - nb; i--) begin
			#5 sda = b[i]; // msb first
			#10 scl = 1'b1;
			#15 scl = 1'b0;
		end
		if (nb == 8) begin
			#5 sda = 1'b1; // released, so the pull-up shows unless acked
			#10 scl = 1'b1;
			if (sda_oe === 1'b1) acks++;
			#15 scl = 1'b0;
		end
	endtask
	// address, zero command and a count lead every frame
	task automatic frame(input logic [7:0] a, input int n, input logic [55:0] d, input int tail);
		acks = 0;
		sda = 1'b0;
		#60 scl = 1'b0;
		put(a, 8);
		put(8'h00, 8);
		put(8'(n), 8);
		for (int k = 0; k < n; k++) put(d[8*k +: 8], 8); // lowest byte first
		if (tail > 0) put(d[8*n +: 8], tail);
		#5 sda = 1'b0;
		#10 scl = 1'b1;
		#15 sda = 1'b1;
		#60;
	endtask
endmodule // cgscb_ctl
`default_nettype wire

// [cgscb_link.sv]
// two-wire receiver running on the link clock
`timescale 1ns/1ns
`default_nettype none
module cgscb_link (
	input  wire logic               scl_clk,
	input  wire logic               frame_rst,
	input  wire logic               init_rst,
	input  wire logic               sda_in,
	output var  logic               sda_out,
	output var  logic               sda_oe,
	output var  cgscb_pkg::cgscb_wr_s wr_word,
	output var  logic               wr_tgl
);
	typedef struct packed {
		logic [3:0]           bit_cnt;
		logic [7:0]           shreg;
		logic [5:0]           byte_cnt;
		logic                 matched;
		cgscb_pkg::cgscb_wr_s wr;
	} cgscb_link_s;

	cgscb_link_s st_q;
	cgscb_link_s st_d;
	logic        tgl_q;
	logic        tgl_d;
	logic        oe_q;
	logic [7:0]  full_byte;
	logic [5:0]  data_pos;

	always_comb begin
		st_d      = st_q;
		tgl_d     = tgl_q;
		full_byte = {st_q.shreg[6:0], sda_in};
		data_pos  = st_q.byte_cnt - cgscb_pkg::POS_FIRST_DATA;
		if (st_q.bit_cnt == cgscb_pkg::BIT_ACK) begin
			st_d.bit_cnt = 4'h0;
			if (st_q.byte_cnt != cgscb_pkg::BYTE_CNT_MAX)
				st_d.byte_cnt = st_q.byte_cnt + 6'h01;
		end else begin
			st_d.shreg   = full_byte;
			st_d.bit_cnt = st_q.bit_cnt + 4'h1;
			if (st_q.bit_cnt == cgscb_pkg::BIT_LAST_DATA) begin
				if (st_q.byte_cnt == cgscb_pkg::POS_ADDR) begin
					// read requests carry a different address and go unanswered
					st_d.matched = (full_byte == cgscb_pkg::SLAVE_ADDR_WR);
				end else if (st_q.matched && st_q.byte_cnt >= cgscb_pkg::POS_FIRST_DATA
						&& data_pos < 6'(cgscb_pkg::NUM_BYTES)) begin
					// command and count are skipped; data fills from byte 0 up
					st_d.wr.idx  = data_pos[2:0];
					st_d.wr.data = full_byte;
					tgl_d        = ~tgl_q;
				end
			end
		end
	end

	always_ff @(posedge scl_clk or posedge frame_rst) begin
		if (frame_rst)
			st_q <= '0;
		else
			st_q <= st_d;
	end

	// survives frame resets so the system side sees no false toggle
	always_ff @(posedge scl_clk or posedge init_rst) begin
		if (init_rst)
			tgl_q <= 1'b0;
		else
			tgl_q <= tgl_d;
	end

	// ack changes on the falling edge so data never moves while scl is high
	always_ff @(negedge scl_clk or posedge frame_rst) begin
		if (frame_rst)
			oe_q <= 1'b0;
		else
			oe_q <= (st_q.bit_cnt == cgscb_pkg::BIT_ACK) && st_q.matched;
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_q;
	assign wr_word = st_q.wr;
	assign wr_tgl  = tgl_q;
endmodule // cgscb_link
`default_nettype wire

// [cgscb_pkg.sv]
// constants and carriers for the clock generator serial configuration bank
package cgscb_pkg;

	localparam int unsigned NUM_BYTES      = 7;
	localparam int unsigned IDX_W          = 3;
	localparam int unsigned BYTE_W         = 8;
	localparam int unsigned BIT_CNT_W      = 4;
	localparam int unsigned BYTE_CNT_W     = 6;

	// frame layout: address, command, count, then data bytes
	localparam logic [7:0] SLAVE_ADDR_WR   = 8'hd2;
	localparam logic [5:0] POS_ADDR        = 6'h00;
	localparam logic [5:0] POS_FIRST_DATA  = 6'h03;
	localparam logic [5:0] BYTE_CNT_MAX    = 6'h3f;
	localparam logic [3:0] BIT_LAST_DATA   = 4'h7;
	localparam logic [3:0] BIT_ACK         = 4'h8;

	// byte indices
	localparam logic [2:0] IDX_MISC        = 3'h0;
	localparam logic [2:0] IDX_MEM_LOW     = 3'h1;
	localparam logic [2:0] IDX_MEM_HIGH    = 3'h2;
	localparam logic [2:0] IDX_PIN_MODE    = 3'h3;
	localparam logic [2:0] IDX_PCI         = 3'h4;
	localparam logic [2:0] IDX_RSVD_FIVE   = 3'h5;
	localparam logic [2:0] IDX_RSVD_SIX    = 3'h6;

	// reset values
	localparam logic [7:0] RST_MISC        = 8'h06;
	localparam logic [7:0] RST_MEM_LOW     = 8'hff;
	localparam logic [7:0] RST_MEM_HIGH    = 8'hff;
	localparam logic [7:0] RST_PIN_MODE    = 8'h02;
	localparam logic [7:0] RST_PCI         = 8'h07;
	localparam logic [7:0] RST_RSVD_FIVE   = 8'h00;
	localparam logic [7:0] RST_RSVD_SIX    = 8'h00;

	// field positions
	localparam int unsigned MISC_SPREAD    = 3;
	localparam int unsigned MISC_DOT       = 2;
	localparam int unsigned MISC_USB       = 1;
	localparam int unsigned MEMH_GFX       = 7;
	localparam int unsigned MEMH_MEM_HI    = 6;
	localparam int unsigned MEMH_MEM_LO    = 2;
	localparam int unsigned MEMH_PCI1      = 1;
	localparam int unsigned PIN_PWRDN_SEL  = 1;
	localparam int unsigned PIN_MEM133     = 0;
	localparam int unsigned PCI_HI         = 2;

	typedef struct packed {
		logic [2:0] idx;
		logic [7:0] data;
	} cgscb_wr_s;

endpackage

// [cgscb_sva.sv]
// assertions on the configuration bank ports
`timescale 1ns/1ns
`default_nettype none
module cgscb_sva #(
	parameter int unsigned NUM_BYTES = 7
) (
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        sda_out,
	input wire logic        sda_oe,
	input wire logic [12:0] memory_clock_outputs_en,
	input wire logic        fixed66_graphics_port_clock_en,
	input wire logic [3:0]  pci_slot_clock_outputs_en,
	input wire logic        usb_clock_en,
	input wire logic        dot_clock_en,
	input wire logic        spread_enable,
	input wire logic        power_down_input_n_select,
	input wire logic        mem133_mode_enable,
	input wire logic [55:0] config_bytes
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	property p_mem; memory_clock_outputs_en == {config_bytes[22:18], config_bytes[15:8]}; endproperty
	a_mem: assert property (p_mem) else $error("memory enables off");
	property p_gfx; fixed66_graphics_port_clock_en == config_bytes[23]; endproperty
	a_gfx: assert property (p_gfx) else $error("graphics enable off");
	property p_pci; pci_slot_clock_outputs_en == {config_bytes[34:32], config_bytes[17]}; endproperty
	a_pci: assert property (p_pci) else $error("pci enables off");
	property p_misc; {spread_enable, dot_clock_en, usb_clock_en} == config_bytes[3:1]; endproperty
	a_misc: assert property (p_misc) else $error("byte zero outputs off");
	property p_pin; {power_down_input_n_select, mem133_mode_enable} == config_bytes[25:24]; endproperty
	a_pin: assert property (p_pin) else $error("pin mode outputs off");
	property p_rst; $rose(resetn) |-> config_bytes == 56'h00_00_07_02_ff_ff_06; endproperty
	a_rst: assert property (p_rst) else $error("defaults not loaded");
	property p_od; sda_out == 1'b0; endproperty
	a_od: assert property (p_od) else $error("data line driven high");
	// ack is one link period, 30 ns, so it falls within a few system clocks
	property p_ack; $rose(sda_oe) |-> ##[2:4] !sda_oe; endproperty
	a_ack: assert property (p_ack) else $error("ack too long");
endmodule // cgscb_sva
bind cgscb_top cgscb_sva #(.NUM_BYTES(NUM_BYTES)) cgscb_sva_i (.clk(clk), .resetn(resetn),
	.sda_out(sda_out), .sda_oe(sda_oe), .memory_clock_outputs_en(memory_clock_outputs_en),
	.fixed66_graphics_port_clock_en(fixed66_graphics_port_clock_en),
	.pci_slot_clock_outputs_en(pci_slot_clock_outputs_en), .usb_clock_en(usb_clock_en),
	.dot_clock_en(dot_clock_en), .spread_enable(spread_enable),
	.power_down_input_n_select(power_down_input_n_select),
	.mem133_mode_enable(mem133_mode_enable), .config_bytes(config_bytes));
`default_nettype wire

// [cgscb_top.sv]
// serial configuration register bank of the clock generator
// Summary of operation
// - bytes arrive in ascending order, each byte most significant bit first.
// - each register keeps exactly the last value written to it.
// - cleared enable holds that clock output low; set lets it run.
// - byte 0 bit 3 turns down-spread modulation on, default off.
// - byte 0 bit 2 enables dot clock, bit 1 usb clock, both default on.
// - byte 1 bits enable memory clocks 7 to 0, default on.
// - byte 2 enables graphics clock, memory clocks 12-8, pci clock 1, default on.
// - byte 3 bit 1 picks shared pin role: 1 power-down, 0 three-state.
// - byte 3 bit 0 enables 133 MHz memory clock mode, default off.
// - byte 4 bits 2 to 0 enable pci clocks 4 to 2, default on.
// - bytes 5 and 6 are reserved, default zero, control nothing.
// - only block writes, filled from lowest byte, may stop after any byte.
// - command byte and byte count are discarded; only data is stored.
// - write-only slave at its fixed address, acknowledging every byte.
`timescale 1ns/1ns
`default_nettype none
module cgscb_top #(
	parameter int unsigned NUM_BYTES = cgscb_pkg::NUM_BYTES
) (
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        scl_clk,
	input  wire logic        sda_in,
	output var  logic        sda_out,
	output var  logic        sda_oe,
	output var  logic [12:0] memory_clock_outputs_en,
	output var  logic        fixed66_graphics_port_clock_en,
	output var  logic [3:0]  pci_slot_clock_outputs_en,
	output var  logic        usb_clock_en,
	output var  logic        dot_clock_en,
	output var  logic        spread_enable,
	output var  logic        power_down_input_n_select,
	output var  logic        mem133_mode_enable,
	output var  logic [55:0] config_bytes
);
	// refused at elaboration: the byte map and the field positions are fixed
	if (NUM_BYTES != cgscb_pkg::NUM_BYTES) begin : g_bad_bytes
		$error("byte count of the bank is fixed by the map");
	end

	typedef struct packed {
		logic        scl_s1;
		logic        scl_s2;
		logic        sda_s1;
		logic        sda_s2;
		logic        sda_s3;
		logic        idle;
		logic        init;
		logic        tgl_s1;
		logic        tgl_s2;
		logic        tgl_s3;
		logic [6:0][7:0] cfg;
	} cgscb_top_s;

	cgscb_top_s           st_q;
	cgscb_top_s           st_d;
	cgscb_pkg::cgscb_wr_s wr_word;
	logic                 wr_tgl;
	logic                 link_sda_out;
	logic                 link_sda_oe;

	cgscb_link u_link (
		.scl_clk   (scl_clk),
		.frame_rst (st_q.idle),
		.init_rst  (st_q.init),
		.sda_in    (sda_in),
		.sda_out   (link_sda_out),
		.sda_oe    (link_sda_oe),
		.wr_word   (wr_word),
		.wr_tgl    (wr_tgl)
	);

	always_comb begin
		st_d        = st_q;
		st_d.scl_s1 = scl_clk;
		st_d.scl_s2 = st_q.scl_s1;
		st_d.sda_s1 = sda_in;
		st_d.sda_s2 = st_q.sda_s1;
		st_d.sda_s3 = st_q.sda_s2;
		st_d.tgl_s1 = wr_tgl;
		st_d.tgl_s2 = st_q.tgl_s1;
		st_d.tgl_s3 = st_q.tgl_s2;
		st_d.init   = 1'b0;
		// start opens a frame, stop closes it; the link clock may halt in between
		if (st_q.scl_s2 && st_q.sda_s3 && !st_q.sda_s2)
			st_d.idle = 1'b0;
		else if (st_q.scl_s2 && !st_q.sda_s3 && st_q.sda_s2)
			st_d.idle = 1'b1;
		// word holds from the toggle until the next data byte, or until the stop clears it
		if (st_q.tgl_s2 != st_q.tgl_s3)
			st_d.cfg[wr_word.idx] = wr_word.data;
		if (!resetn) begin
			st_d.idle   = 1'b1;
			st_d.init   = 1'b1;
			st_d.cfg[cgscb_pkg::IDX_MISC]      = cgscb_pkg::RST_MISC;
			st_d.cfg[cgscb_pkg::IDX_MEM_LOW]   = cgscb_pkg::RST_MEM_LOW;
			st_d.cfg[cgscb_pkg::IDX_MEM_HIGH]  = cgscb_pkg::RST_MEM_HIGH;
			st_d.cfg[cgscb_pkg::IDX_PIN_MODE]  = cgscb_pkg::RST_PIN_MODE;
			st_d.cfg[cgscb_pkg::IDX_PCI]       = cgscb_pkg::RST_PCI;
			st_d.cfg[cgscb_pkg::IDX_RSVD_FIVE] = cgscb_pkg::RST_RSVD_FIVE;
			st_d.cfg[cgscb_pkg::IDX_RSVD_SIX]  = cgscb_pkg::RST_RSVD_SIX;
		end
	end

	always_ff @(posedge clk) begin
		st_q <= st_d;
	end

	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;
	assign b0 = st_q.cfg[cgscb_pkg::IDX_MISC];
	assign b1 = st_q.cfg[cgscb_pkg::IDX_MEM_LOW];
	assign b2 = st_q.cfg[cgscb_pkg::IDX_MEM_HIGH];
	assign b3 = st_q.cfg[cgscb_pkg::IDX_PIN_MODE];
	assign b4 = st_q.cfg[cgscb_pkg::IDX_PCI];

	// enables gate the output drivers outside; a low enable parks the output low
	assign memory_clock_outputs_en =
		{b2[cgscb_pkg::MEMH_MEM_HI:cgscb_pkg::MEMH_MEM_LO], b1};
	assign fixed66_graphics_port_clock_en = b2[cgscb_pkg::MEMH_GFX];
	assign pci_slot_clock_outputs_en = {b4[cgscb_pkg::PCI_HI:0], b2[cgscb_pkg::MEMH_PCI1]};
	assign usb_clock_en              = b0[cgscb_pkg::MISC_USB];
	assign dot_clock_en              = b0[cgscb_pkg::MISC_DOT];
	assign spread_enable             = b0[cgscb_pkg::MISC_SPREAD];
	assign power_down_input_n_select = b3[cgscb_pkg::PIN_PWRDN_SEL];
	assign mem133_mode_enable        = b3[cgscb_pkg::PIN_MEM133];
	assign config_bytes              = st_q.cfg;
	assign sda_out                   = link_sda_out;
	assign sda_oe                    = link_sda_oe;
endmodule // cgscb_top
`default_nettype wire
